/* File: cmp_pkg.sv */
// constants and types shared by both ends of the strap and serial link
// Functional notes
// [RULE1] floating full-scale pin selects extended control mode
// [RULE2] full-scale pin driven high/low picks range
// [RULE3] non-extended mode: serial port off, straps only
// [RULE4] swing pin: low reduced, high normal swing
// [RULE5] edge pin: high rising, low falling launch
// [RULE6] edge pin floating gives double-data-rate clock
// [RULE7] delay pin: high long, low short; never float
// [RULE8] extended: swing/edge/delay pins become serial port
// [RULE9] host writes all user registers before use
// [RULE10] first interleave register write loads default
// [RULE11] other settings only after all registers written
// [RULE12] straps decoded three-level, applied in clock domain
package cmp_pkg;
   typedef enum logic [1:0] {
      LVL_LOW   = 2'h0,
      LVL_HIGH  = 2'h1,
      LVL_FLOAT = 2'h2
   } cmp_level_e;
   // pin indices on the link
   localparam int PIN_SWING  = 0;
   localparam int PIN_EDGE   = 1;
   localparam int PIN_DELAY  = 2;
   localparam int PIN_FSCALE = 3;
   // serial frame: 4 address bits then 16 data bits, msb first
   localparam int FRAME_BITS = 20;
   localparam int ADDR_LSB   = 16;
   localparam logic [4:0] FRAME_BITS5 = 5'h14;
   // device register map
   localparam logic [3:0]  REG_CONFIG       = 4'h1;
   localparam logic [3:0]  REG_INTERLEAVE   = 4'hD;
   localparam logic [15:0] INTERLEAVE_RESET = 16'h3FFF;
   localparam logic [15:0] REG_RESET        = 16'h0000;
   localparam int          INTERLEAVE_EN    = 15;
   localparam logic [15:0] USER_REG_MASK    = 16'h6E0E;
   // config register fields, used in extended mode
   localparam int CFG_FSCALE = 0;
   localparam int CFG_SWING  = 1;
   localparam int CFG_EDGE   = 2;
   localparam int CFG_DDR    = 3;
   localparam int CFG_DELAY  = 4;
   // timing in clock cycles
   localparam logic [7:0] PROBE_CYCLES = 8'h10;
   localparam logic [3:0] SCLK_HALF    = 4'h4;
   localparam logic [3:0] SEL_LEAD     = 4'h2;
   localparam logic [3:0] FRAME_GAP    = 4'h8;
   // host wishbone map and fields
   localparam logic [7:0]  WB_CTRL       = 8'h00;
   localparam logic [7:0]  WB_CMD        = 8'h04;
   localparam logic [7:0]  WB_STATUS     = 8'h08;
   localparam logic [7:0]  CTRL_RESET    = 8'h45;
   localparam int          ST_BUSY       = 0;
   localparam int          ST_ALLDONE    = 1;
   localparam int          ST_REFUSED    = 2;
   localparam int          ST_MASK_LSB   = 16;

   function automatic logic cmpIsUser(input logic [3:0] addr);
      return USER_REG_MASK[addr];
   endfunction
endpackage

/* File: cmp_link_if.sv */
// strap and serial pins shared by host and device
`timescale 1ns/10ps
`default_nettype none
interface cmp_link_if;
   logic [3:0] hostOut;
   logic [3:0] hostOe;
   logic [3:0] devPull;
   logic [3:0] pinLevel;
   // an undriven pin follows the device's weak probe pull
   assign pinLevel = (hostOe & hostOut) | (~hostOe & devPull);
   modport host (output hostOut, output hostOe);
   modport device (input pinLevel, output devPull);
endinterface
`default_nettype wire

/* File: cmp_device.sv */
// device end: three-level strap decode and serial configuration port
`timescale 1ns/10ps
`default_nettype none
module cmp_device
   import cmp_pkg::*;
(
   // clock and reset
   input  wire logic    mclk,
   input  wire logic    rst,
   // strap and serial pins
   cmp_link_if.device   link,
   // decoded settings
   output logic         decodeValid,
   output logic         extendedMode,
   output logic         fullScaleNormal,
   output logic         swingNormal,
   output logic         launchPositive,
   output logic         ddrClock,
   output logic         calDelayLong,
   // configuration state
   output logic         configComplete,
   output logic         interleaveOn
);
   logic [3:0]  pinMeta_q;
   logic [3:0]  pinSync_q;
   logic [7:0]  probeCnt_q;
   logic        probePull_q;
   logic [3:0]  seenLow_q;
   logic        seenLowValid_q;
   logic        decodeStrobe;
   cmp_level_e  lvl [4];
   logic        serialClk;
   logic        selectIdle;
   logic        serialData;
   logic [4:0]  bitCnt_q;
   logic        frameDone_q;
   logic [19:0] shift_q;
   logic        doneMeta_q;
   logic        doneSync_q;
   logic        doneSeen_q;
   logic        wordStrobe;
   logic [3:0]  wordAddr;
   logic [15:0] wordData;
   logic [15:0] regFile_q [16];
   logic [15:0] writtenMask_q;
   logic        allWritten;

   function automatic cmp_level_e levelOf(input logic pulledHigh, input logic pulledLow);
      if (pulledHigh && !pulledLow) begin
         return LVL_FLOAT;
      end
      return pulledHigh ? LVL_HIGH : LVL_LOW;
   endfunction

   // pins come from the other party: two flops first
   always_ff @(posedge mclk) begin
      pinMeta_q <= link.pinLevel;
      pinSync_q <= pinMeta_q;
   end

   // weak pull alternates; a pin that follows it in both phases floats
   always_ff @(posedge mclk) begin
      if (rst) begin
         probeCnt_q  <= 8'h00;
         probePull_q <= 1'b0;
      end else if (probeCnt_q == PROBE_CYCLES - 8'h01) begin
         probeCnt_q  <= 8'h00;
         probePull_q <= ~probePull_q;
      end else begin
         probeCnt_q <= probeCnt_q + 8'h01;
      end
   end

   assign link.devPull = {4{probePull_q}};

   always_ff @(posedge mclk) begin
      if (rst) begin
         seenLow_q      <= 4'h0;
         seenLowValid_q <= 1'b0;
      end else if (probeCnt_q == PROBE_CYCLES - 8'h01 && !probePull_q) begin
         seenLow_q      <= pinSync_q;
         seenLowValid_q <= 1'b1;
      end
   end

   assign decodeStrobe = (probeCnt_q == PROBE_CYCLES - 8'h01) && probePull_q && seenLowValid_q;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lvl[i] = levelOf(pinSync_q[i], seenLow_q[i]); // [RULE12]
      end
   end

   // settings are applied only on the decode strobe, inside this domain
   always_ff @(posedge mclk) begin
      if (rst) begin
         decodeValid     <= 1'b0;
         extendedMode    <= 1'b0;
         fullScaleNormal <= 1'b1;
         swingNormal     <= 1'b1;
         launchPositive  <= 1'b1;
         ddrClock        <= 1'b0;
         calDelayLong    <= 1'b0;
      end else if (decodeStrobe) begin
         decodeValid  <= 1'b1;
         extendedMode <= (lvl[PIN_FSCALE] == LVL_FLOAT); // [RULE1]
         if (lvl[PIN_FSCALE] == LVL_FLOAT) begin
            // options come from the config register instead of straps
            fullScaleNormal <= regFile_q[REG_CONFIG][CFG_FSCALE];
            swingNormal     <= regFile_q[REG_CONFIG][CFG_SWING];
            launchPositive  <= regFile_q[REG_CONFIG][CFG_EDGE];
            ddrClock        <= regFile_q[REG_CONFIG][CFG_DDR];
            calDelayLong    <= regFile_q[REG_CONFIG][CFG_DELAY];
         end else begin
            fullScaleNormal <= (lvl[PIN_FSCALE] == LVL_HIGH); // [RULE2] [RULE3]
            if (lvl[PIN_SWING] != LVL_FLOAT) begin
               swingNormal <= (lvl[PIN_SWING] == LVL_HIGH); // [RULE4]
            end
            if (lvl[PIN_EDGE] == LVL_FLOAT) begin
               ddrClock <= 1'b1; // [RULE6]
            end else begin
               ddrClock       <= 1'b0;
               launchPositive <= (lvl[PIN_EDGE] == LVL_HIGH); // [RULE5]
            end
            if (lvl[PIN_DELAY] != LVL_FLOAT) begin
               calDelayLong <= (lvl[PIN_DELAY] == LVL_HIGH); // [RULE7]
            end
         end
      end
   end

   // link domain: pins take their serial roles
   assign serialClk  = link.pinLevel[PIN_SWING]; // [RULE8]
   assign serialData = link.pinLevel[PIN_EDGE]; // [RULE8]
   assign selectIdle = link.pinLevel[PIN_DELAY]; // [RULE8]

   // select high clears the frame, since the clock stops between frames
   always_ff @(posedge serialClk or posedge selectIdle) begin
      if (selectIdle) begin
         bitCnt_q    <= 5'h00;
         frameDone_q <= 1'b0;
      end else if (bitCnt_q != FRAME_BITS5) begin
         bitCnt_q    <= bitCnt_q + 5'h01;
         frameDone_q <= (bitCnt_q == FRAME_BITS5 - 5'h01);
      end
   end

   always_ff @(posedge serialClk) begin
      if (bitCnt_q != FRAME_BITS5) begin
         shift_q <= {shift_q[18:0], serialData};
      end
   end

   // done level crosses; the word is stable until the next frame
   always_ff @(posedge mclk) begin
      if (rst) begin
         doneMeta_q <= 1'b0;
         doneSync_q <= 1'b0;
         doneSeen_q <= 1'b0;
      end else begin
         doneMeta_q <= frameDone_q;
         doneSync_q <= doneMeta_q;
         doneSeen_q <= doneSync_q;
      end
   end

   assign wordStrobe = doneSync_q && !doneSeen_q && extendedMode; // [RULE3]
   assign wordAddr   = shift_q[FRAME_BITS-1:ADDR_LSB];
   assign wordData   = shift_q[ADDR_LSB-1:0];

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) begin
            regFile_q[i] <= REG_RESET;
         end
         regFile_q[REG_INTERLEAVE] <= INTERLEAVE_RESET;
         writtenMask_q             <= 16'h0000;
      end else if (wordStrobe && cmpIsUser(wordAddr)) begin
         regFile_q[wordAddr]     <= wordData;
         writtenMask_q[wordAddr] <= 1'b1;
      end
   end

   assign allWritten = ((writtenMask_q & USER_REG_MASK) == USER_REG_MASK);

   // interleave is honoured only once every user register was loaded
   always_ff @(posedge mclk) begin
      if (rst) begin
         configComplete <= 1'b0;
         interleaveOn   <= 1'b0;
      end else begin
         configComplete <= allWritten; // [RULE9]
         interleaveOn   <= allWritten && extendedMode
                           && regFile_q[REG_INTERLEAVE][INTERLEAVE_EN]; // [RULE11]
      end
   end
endmodule // cmp_device
`default_nettype wire

/* File: cmp_host.sv */
// host end: drives straps or runs the serial port, wishbone controlled
`timescale 1ns/10ps
`default_nettype none
module cmp_host
   import cmp_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // strap and serial pins
   cmp_link_if.host         link
);
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_LEAD = 5'h02,
      S_LOW  = 5'h04,
      S_HIGH = 5'h08,
      S_TAIL = 5'h10
   } cmp_state_e;

   cmp_state_e  state_q;
   logic [7:0]  ctrl_q;
   logic [3:0]  cnt_q;
   logic [4:0]  bitIdx_q;
   logic [19:0] tx_q;
   logic        sclk_q;
   logic        sdat_q;
   logic        sel_q;
   logic [15:0] writtenMask_q;
   logic        refused_q;
   logic        extended;
   logic        allWritten;
   logic        wrTake;
   logic        cmdWrite;
   logic [3:0]  cmdAddr;
   logic [15:0] cmdData;
   logic        cmdOk;
   logic        start;

   assign extended   = (cmp_level_e'(ctrl_q[7:6]) == LVL_FLOAT);
   assign allWritten = ((writtenMask_q & USER_REG_MASK) == USER_REG_MASK);
   assign wrTake     = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign cmdWrite   = wrTake && wb_adr_i == WB_CMD;
   assign cmdAddr    = wb_dat_i[FRAME_BITS-1:ADDR_LSB];
   assign cmdData    = wb_dat_i[ADDR_LSB-1:0];
   assign cmdOk      = extended && state_q == S_IDLE && cmpIsUser(cmdAddr)
                       && !(writtenMask_q[cmdAddr] && !allWritten) // [RULE11]
                       && !(cmdAddr == REG_INTERLEAVE && !writtenMask_q[REG_INTERLEAVE]
                            && cmdData != INTERLEAVE_RESET) // [RULE10]
                       && !(cmdAddr == REG_INTERLEAVE && cmdData[INTERLEAVE_EN]
                            && !allWritten); // [RULE11]
   assign start      = cmdWrite && cmdOk;

   // one wait state; write lands at the edge the master sees ack
   always_ff @(posedge mclk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         if (wb_adr_i == WB_CTRL) begin
            wb_dat_o <= {24'h00_0000, ctrl_q};
         end else if (wb_adr_i == WB_STATUS) begin
            wb_dat_o <= {writtenMask_q, 13'h0000, refused_q, allWritten,
                         state_q != S_IDLE};
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_q <= CTRL_RESET;
      end else if (wrTake && wb_adr_i == WB_CTRL && wb_sel_i[0] && state_q == S_IDLE) begin
         ctrl_q <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         writtenMask_q <= 16'h0000;
         refused_q     <= 1'b0;
      end else if (cmdWrite) begin
         refused_q <= !cmdOk;
         if (cmdOk) begin
            writtenMask_q[cmdAddr] <= 1'b1; // [RULE9]
         end
      end
   end

   // serial engine: data set while clock low, device samples rising edge
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q  <= S_IDLE;
         cnt_q    <= 4'h0;
         bitIdx_q <= 5'h00;
         tx_q     <= 20'h0_0000;
         sclk_q   <= 1'b0;
         sdat_q   <= 1'b0;
         sel_q    <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 4'h1;
         case (state_q)
            S_IDLE: begin
               cnt_q <= 4'h0;
               if (start) begin
                  tx_q     <= {cmdAddr, cmdData};
                  bitIdx_q <= 5'h00;
                  sel_q    <= 1'b0;
                  state_q  <= S_LEAD;
               end
            end
            S_LEAD: begin
               if (cnt_q == SEL_LEAD - 4'h1) begin
                  cnt_q   <= 4'h0;
                  sdat_q  <= tx_q[19];
                  state_q <= S_LOW;
               end
            end
            S_LOW: begin
               if (cnt_q == SCLK_HALF - 4'h1) begin
                  cnt_q   <= 4'h0;
                  sclk_q  <= 1'b1;
                  state_q <= S_HIGH;
               end
            end
            S_HIGH: begin
               if (cnt_q == SCLK_HALF - 4'h1) begin
                  cnt_q  <= 4'h0;
                  sclk_q <= 1'b0;
                  if (bitIdx_q == FRAME_BITS5 - 5'h01) begin
                     state_q <= S_TAIL;
                  end else begin
                     bitIdx_q <= bitIdx_q + 5'h01;
                     tx_q     <= {tx_q[18:0], 1'b0};
                     sdat_q   <= tx_q[18];
                     state_q  <= S_LOW;
                  end
               end
            end
            S_TAIL: begin
               sel_q <= 1'b1;
               if (cnt_q == FRAME_GAP - 4'h1) begin
                  state_q <= S_IDLE;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // pin drive: straps driven firmly except a float edge code, which leaves the edge pin undriven, or serial roles in extended mode
   always_ff @(posedge mclk) begin
      if (rst) begin
         link.hostOut <= 4'h0;
         link.hostOe  <= 4'h0;
      end else if (extended) begin
         link.hostOe  <= 4'h7; // [RULE1]
         link.hostOut <= {1'b0, sel_q, sdat_q, sclk_q}; // [RULE8]
      end else begin
         link.hostOe[PIN_FSCALE]  <= 1'b1; // [RULE2]
         link.hostOut[PIN_FSCALE] <= (cmp_level_e'(ctrl_q[7:6]) == LVL_HIGH);
         link.hostOe[PIN_SWING]   <= 1'b1; // [RULE4]
         link.hostOut[PIN_SWING]  <= (cmp_level_e'(ctrl_q[1:0]) != LVL_LOW);
         link.hostOe[PIN_EDGE]    <= (cmp_level_e'(ctrl_q[3:2]) != LVL_FLOAT); // [RULE6]
         link.hostOut[PIN_EDGE]   <= (cmp_level_e'(ctrl_q[3:2]) == LVL_HIGH);
         link.hostOe[PIN_DELAY]   <= 1'b1; // [RULE7]
         link.hostOut[PIN_DELAY]  <= (cmp_level_e'(ctrl_q[5:4]) != LVL_LOW);
      end
   end
endmodule // cmp_host
`default_nettype wire

/* File: cmp_link_checker.sv */
// assertions on the strap and serial wires between host and device
`timescale 1ns/10ps
`default_nettype none
module cmp_link_checker (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // link wires
   input  wire logic [3:0] hostOut,
   input  wire logic [3:0] hostOe,
   input  wire logic [3:0] devPull,
   input  wire logic [3:0] pinLevel
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic frameOn;
   // full-scale pin released and select low: a serial frame is under way
   assign frameOn = !hostOe[3] && !pinLevel[2];

   a_pull_reset: assert property (disable iff (1'b0) rst |=> devPull == 4'h0)
      else $error("probe pull not cleared by reset");
   a_host_reset: assert property (disable iff (1'b0) rst |=> hostOe == 4'h0)
      else $error("host drives pins during reset");
   a_pull_uniform: assert property (devPull == 4'h0 || devPull == 4'hF)
      else $error("probe pull bits disagree");
   a_pull_hold: assert property ($changed(devPull) |=> $stable(devPull) [*8])
      else $error("probe phase too short");
   a_sclk_high: assert property (frameOn && $rose(pinLevel[0]) |->
      pinLevel[0] [*4] ##1 !pinLevel[0])
      else $error("serial clock high phase not four cycles");
   a_data_stable: assert property (frameOn && pinLevel[0] && $past(pinLevel[0]) |->
      $stable(pinLevel[1]))
      else $error("serial data moved while clock high");
   a_sel_hold: assert property (frameOn && $fell(pinLevel[2]) |-> !pinLevel[2] [*8])
      else $error("select frame too short");
   a_sel_gap: assert property (!hostOe[3] && $rose(pinLevel[2]) |-> pinLevel[2] [*4])
      else $error("select gap too short");
endmodule // cmp_link_checker
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench: host and device joined over the strap link
`timescale 1ns/10ps
`default_nettype none
module tb_top import cmp_pkg::*;;
   logic        mclk;
   logic        rst;
   logic        wbCyc;
   logic        wbStb;
   logic        wbWe;
   logic [7:0]  wbAdr;
   logic [31:0] wbDatI;
   logic [31:0] wbDatO;
   logic        wbAck;
   logic [8:0]  flags;
   logic [31:0] rd;
   int          errTotal;
   int          testsRun;
   logic [3:0]  restRegs [6] = '{4'h2, 4'h3, 4'h9, 4'hA, 4'hB, 4'hE};

   cmp_link_if linkBus ();
   cmp_host cmp_host_inst (.mclk(mclk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .link(linkBus.host));
   cmp_device cmp_device_inst (.mclk(mclk), .rst(rst), .link(linkBus.device),
      .decodeValid(flags[8]), .extendedMode(flags[7]), .fullScaleNormal(flags[6]),
      .swingNormal(flags[5]), .launchPositive(flags[4]), .ddrClock(flags[3]),
      .calDelayLong(flags[2]), .configComplete(flags[1]), .interleaveOn(flags[0]));
   cmp_link_checker cmp_link_checker_inst (.mclk(mclk), .rst(rst),
      .hostOut(linkBus.hostOut), .hostOe(linkBus.hostOe), .devPull(linkBus.devPull),
      .pinLevel(linkBus.pinLevel));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         errTotal++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // one classic wishbone cycle; read data lands in rd
   task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatI <= d;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wbAck !== 1'b1 && n < 50);
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (wbAck !== 1'b1) begin
         errTotal++;
         results();
      end
   endtask

   // poll status until the serial frame is finished
   task automatic waitIdle();
      int n;
      n = 0;
      do begin
         wbXfer(1'b0, WB_STATUS, 32'h0);
         n++;
      end while (rd[ST_BUSY] !== 1'b0 && n < 200);
      if (rd[ST_BUSY] !== 1'b0) begin
         errTotal++;
         results();
      end
   endtask

   task automatic cmd(input logic [3:0] a, input logic [15:0] d, input logic refused);
      wbXfer(1'b1, WB_CMD, {12'h000, a, d});
      waitIdle();
      check("refused", {31'h0, rd[ST_REFUSED]}, {31'h0, refused});
   endtask

   // set strap codes, let the device decode, compare its settings
   task automatic strap(input logic [7:0] code, input logic [8:0] exp, input logic [8:0] mask);
      wbXfer(1'b1, WB_CTRL, {24'h0, code});
      repeat (80) @(posedge mclk);
      check("settings", {23'h0, flags & mask}, {23'h0, exp});
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   initial begin
      rst = 1'b1;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 8'h00;
      wbDatI = 32'h0;
      errTotal = 0;
      testsRun = 0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      repeat (48) @(posedge mclk);
      check("settings", {23'h0, flags}, 32'h170);
      wbXfer(1'b0, WB_CTRL, 32'h0);
      check("ctrl", rd, 32'h45);
      wbXfer(1'b1, 8'h0C, 32'hFFFF_FFFF);
      wbXfer(1'b0, 8'h0C, 32'h0);
      check("unmapped", rd, 32'h0);
      $display("test reset done");
      strap(8'h10, 9'h104, 9'h1FF);
      strap(8'h49, 9'h168, 9'h1EF);
      strap(8'h05, 9'h130, 9'h1FF);
      cmd(4'h1, 16'h0012, 1'b1);
      $display("test straps done");
      strap(8'hAA, 9'h180, 9'h183);
      cmd(4'hD, 16'h0001, 1'b1);
      cmd(4'hD, 16'h3FFF, 1'b0);
      cmd(4'hD, 16'h8000, 1'b1);
      cmd(4'h1, 16'h0012, 1'b0);
      cmd(4'h1, 16'h0012, 1'b1);
      cmd(4'h4, 16'h0000, 1'b1);
      check("settings", {30'h0, flags[1:0]}, 32'h0);
      foreach (restRegs[i]) begin
         cmd(restRegs[i], 16'h0000, 1'b0);
      end
      check("status", rd & 32'hFFFF_0002, 32'h6E0E_0002);
      cmd(4'hD, 16'hBFFF, 1'b0);
      repeat (80) @(posedge mclk);
      // config word 0x0012 sets the swing and delay fields only
      check("settings", {23'h0, flags}, 32'h1A7);
      $display("test serial done");
      results();
   end
endmodule // tb_top
`default_nettype wire
